/* File: rtl/rsf_pkg.sv */
// constants for the ramp status and event flag block
// assumes a single 125 MHz clock and an AXI4-Lite register slave
package rsf_pkg;
  localparam int RSF_ADDR_W = 8;
  localparam logic [5:0] RSF_IDX_STATUS = 6'h2b;
  localparam logic [5:0] RSF_IDX_CTRL = 6'h30;
  localparam logic [1:0] RSF_RESP_OKAY = 2'h0;
  localparam logic [1:0] RSF_RESP_SLVERR = 2'h2;
  localparam int RSF_B_VSTOP_R = 15;
  localparam int RSF_B_VSTOP_L = 14;
  localparam int RSF_B_STALL_IN = 13;
  localparam int RSF_B_SECOND_MOVE = 12;
  localparam int RSF_B_ZEROWAIT = 11;
  localparam int RSF_B_VZERO = 10;
  localparam int RSF_B_POS_REACHED = 9;
  localparam int RSF_B_VEL_REACHED = 8;
  localparam int RSF_B_EV_POS = 7;
  localparam int RSF_B_EV_STALL = 6;
  localparam int RSF_B_EV_STOP_R = 5;
  localparam int RSF_B_EV_STOP_L = 4;
  localparam int RSF_B_SW_R = 1;
  localparam int RSF_B_SW_L = 0;
  localparam int RSF_C_STOP_L_EN = 0;
  localparam int RSF_C_STOP_R_EN = 1;
  localparam int RSF_C_VSTOP_L_EN = 2;
  localparam int RSF_C_VSTOP_R_EN = 3;
  localparam int RSF_C_SOFT_STOP = 4;
  localparam int RSF_C_STALL_EN = 5;
  localparam int RSF_CTRL_W = 6;
  localparam logic [RSF_CTRL_W-1:0] RSF_CTRL_RESET = 6'h00;
endpackage

/* File: rtl/rsf_flag_if.sv */
// signals between the register side and the event flag flops
// assumes both ends share one clock
`timescale 1ns/1ps
interface rsf_flag_if;
  logic clr_second_move;
  logic clr_pos_event;
  logic clr_stall_event;
  logic reversal_seen;
  logic pos_reached;
  logic stall_seen;
  logic stop_l_cond;
  logic stop_r_cond;
  logic stop_l_release;
  logic stop_r_release;
  logic stop_l_keep;
  logic stop_r_keep;
  logic second_move;
  logic pos_event;
  logic stall_event;
  logic stop_l_event;
  logic stop_r_event;
  modport regs (
    output clr_second_move, clr_pos_event, clr_stall_event, reversal_seen, pos_reached,
    output stall_seen, stop_l_cond, stop_r_cond, stop_l_release, stop_r_release,
    output stop_l_keep, stop_r_keep,
    input second_move, pos_event, stall_event, stop_l_event, stop_r_event
  );
  modport flags (
    input clr_second_move, clr_pos_event, clr_stall_event, reversal_seen, pos_reached,
    input stall_seen, stop_l_cond, stop_r_cond, stop_l_release, stop_r_release,
    input stop_l_keep, stop_r_keep,
    output second_move, pos_event, stall_event, stop_l_event, stop_r_event
  );
endinterface

/* File: rtl/rsf_flags.sv */
// event flag flops of the ramp status block
// assumes clear strobes are one-cycle pulses from the register side
`timescale 1ns/1ps
module rsf_flags
  import rsf_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  rsf_flag_if.flags fi
);
  logic second_move_reg;
  logic pos_event_reg;
  logic stall_event_reg;
  logic stop_l_reg;
  logic stop_r_reg;
  logic pos_prev_reg;
  logic second_move_next;
  logic pos_event_next;
  logic stall_event_next;
  logic stop_l_next;
  logic stop_r_next;
  logic pos_rise;

  // sticky flag, a set in the clearing cycle wins
  function automatic logic w1c_next(input logic q, input logic set, input logic clr);
    w1c_next = set | (q & ~clr);
  endfunction

  // stop event follows its condition, may be held by soft stop, dropped by release
  function automatic logic stop_next(input logic q, input logic cond, input logic keep,
                                     input logic release_now);
    stop_next = ~release_now & (cond | (q & keep));
  endfunction

  assign pos_rise = fi.pos_reached & ~pos_prev_reg;
  assign second_move_next = w1c_next(second_move_reg, fi.reversal_seen, fi.clr_second_move);
  assign pos_event_next = w1c_next(pos_event_reg, pos_rise, fi.clr_pos_event);
  assign stall_event_next = w1c_next(stall_event_reg, fi.stall_seen, fi.clr_stall_event);
  assign stop_l_next = stop_next(stop_l_reg, fi.stop_l_cond, fi.stop_l_keep, fi.stop_l_release);
  assign stop_r_next = stop_next(stop_r_reg, fi.stop_r_cond, fi.stop_r_keep, fi.stop_r_release);

  ////////////////////////////////////////////////////////////////////////////////
  // flops, all cleared by reset
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      second_move_reg <= 1'b0;
      pos_event_reg <= 1'b0;
      stall_event_reg <= 1'b0;
      stop_l_reg <= 1'b0;
      stop_r_reg <= 1'b0;
      pos_prev_reg <= 1'b0;
    end
    else
    begin
      second_move_reg <= second_move_next;
      pos_event_reg <= pos_event_next;
      stall_event_reg <= stall_event_next;
      stop_l_reg <= stop_l_next;
      stop_r_reg <= stop_r_next;
      pos_prev_reg <= fi.pos_reached;
    end
  end

  assign fi.second_move = second_move_reg;
  assign fi.pos_event = pos_event_reg;
  assign fi.stall_event = stall_event_reg;
  assign fi.stop_l_event = stop_l_reg;
  assign fi.stop_r_event = stop_r_reg;
endmodule // rsf_flags

/* File: rtl/rsf_top.sv */
// ramp status and event flag block with its AXI4-Lite register slave
// assumes ramp state inputs are synchronous to clock and come from the ramp generator
//
// Chosen here: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
module rsf_top
  import rsf_pkg::*;
#(
  parameter int POS_W = 32,
  parameter int VEL_W = 23
)
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [RSF_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [RSF_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [POS_W-1:0] actual_position,
  input wire logic [POS_W-1:0] target_position,
  input wire logic [VEL_W-1:0] actual_velocity,
  input wire logic [VEL_W-1:0] programmed_top_velocity,
  input wire logic post_stop_wait_interval,
  input wire logic reversal_pulse,
  input wire logic stall_detect,
  input wire logic ref_switch_l,
  input wire logic ref_switch_r,
  input wire logic virtual_stop_l_hit,
  input wire logic virtual_stop_r_hit,
  input wire logic ramp_hold_mode,
  input wire logic move_cmd_left,
  input wire logic move_cmd_right,
  input wire logic moving_left,
  input wire logic moving_right,
  output logic interrupt_out,
  output logic stall_halt_event,
  output logic stop_left_active,
  output logic stop_right_active
);
  rsf_flag_if fi ();

  logic awready_reg;
  logic wready_reg;
  logic aw_held_reg;
  logic w_held_reg;
  logic [RSF_ADDR_W-1:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic arready_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic [RSF_CTRL_W-1:0] ctrl_reg;
  logic irq_reg;
  logic stall_out_reg;
  logic stop_l_out_reg;
  logic stop_r_out_reg;

  logic aw_take;
  logic w_take;
  logic have_aw;
  logic have_w;
  logic [RSF_ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_fire;
  logic wr_status;
  logic wr_ctrl;
  logic wr_mapped;
  logic ar_take;
  logic rd_status;
  logic rd_ctrl;
  logic rd_mapped;
  logic [31:0] status_word;
  logic [31:0] ctrl_word;
  logic [31:0] rd_word;
  logic [RSF_CTRL_W-1:0] ctrl_next;
  logic irq_next;
  logic st_vzero;
  logic st_pos_reached;
  logic st_vel_reached;
  logic stop_l_en;
  logic stop_r_en;
  logic vstop_l_en;
  logic vstop_r_en;
  logic soft_stop;

  // register index from a byte address
  function automatic logic hit(input logic [RSF_ADDR_W-1:0] addr, input logic [5:0] idx);
    hit = addr[RSF_ADDR_W-1:2] == idx;
  endfunction

  // write-one-to-clear strobe for one status bit, byte lane checked
  function automatic logic w1c_hit(input logic [31:0] data, input logic [3:0] strb, input int bit_pos);
    w1c_hit = data[bit_pos] & strb[bit_pos / 8];
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // write channel: address and data in either order, response after both
  assign aw_take = s_axi_awvalid & awready_reg;
  assign w_take = s_axi_wvalid & wready_reg;
  assign have_aw = aw_held_reg | aw_take;
  assign have_w = w_held_reg | w_take;
  assign wr_addr = aw_held_reg ? awaddr_reg : s_axi_awaddr;
  assign wr_data = w_held_reg ? wdata_reg : s_axi_wdata;
  assign wr_strb = w_held_reg ? wstrb_reg : s_axi_wstrb;
  assign wr_fire = have_aw & have_w & ~bvalid_reg;
  assign wr_status = wr_fire & hit(wr_addr, RSF_IDX_STATUS);
  assign wr_ctrl = wr_fire & hit(wr_addr, RSF_IDX_CTRL);
  assign wr_mapped = hit(wr_addr, RSF_IDX_STATUS) | hit(wr_addr, RSF_IDX_CTRL);

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RSF_RESP_OKAY;
    end
    else
    begin
      awready_reg <= ~have_aw & ~bvalid_reg;
      wready_reg <= ~have_w & ~bvalid_reg;
      aw_held_reg <= have_aw & ~wr_fire;
      w_held_reg <= have_w & ~wr_fire;
      if (aw_take)
      begin
        awaddr_reg <= s_axi_awaddr;
      end
      if (w_take)
      begin
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_mapped ? RSF_RESP_OKAY : RSF_RESP_SLVERR;
      end
      else if (s_axi_bready)
      begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read channel: one cycle from address to data
  assign ar_take = s_axi_arvalid & arready_reg;
  assign rd_status = hit(s_axi_araddr, RSF_IDX_STATUS);
  assign rd_ctrl = hit(s_axi_araddr, RSF_IDX_CTRL);
  assign rd_mapped = rd_status | rd_ctrl;
  assign rd_word = rd_status ? status_word : (rd_ctrl ? ctrl_word : 32'h0000_0000);

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= RSF_RESP_OKAY;
    end
    else
    begin
      arready_reg <= ~rvalid_reg & ~ar_take;
      if (ar_take)
      begin
        rvalid_reg <= 1'b1;
        rdata_reg <= rd_word;
        rresp_reg <= rd_mapped ? RSF_RESP_OKAY : RSF_RESP_SLVERR;
      end
      else if (s_axi_rready)
      begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // stop and stall configuration register
  assign ctrl_next = (wr_ctrl & wr_strb[0]) ? wr_data[RSF_CTRL_W-1:0] : ctrl_reg;
  assign stop_l_en = ctrl_reg[RSF_C_STOP_L_EN];
  assign stop_r_en = ctrl_reg[RSF_C_STOP_R_EN];
  assign vstop_l_en = ctrl_reg[RSF_C_VSTOP_L_EN];
  assign vstop_r_en = ctrl_reg[RSF_C_VSTOP_R_EN];
  assign soft_stop = ctrl_reg[RSF_C_SOFT_STOP];
  assign ctrl_word = {{(32 - RSF_CTRL_W){1'b0}}, ctrl_reg};

  ////////////////////////////////////////////////////////////////////////////////
  // status word: live status from the present ramp state plus the latched event flags
  assign st_vzero = actual_velocity == '0;
  assign st_pos_reached = actual_position == target_position;
  assign st_vel_reached = actual_velocity == programmed_top_velocity;

  always_comb
  begin
    status_word = 32'h0000_0000;
    status_word[RSF_B_VSTOP_R] = virtual_stop_r_hit;
    status_word[RSF_B_VSTOP_L] = virtual_stop_l_hit;
    status_word[RSF_B_STALL_IN] = stall_detect;
    status_word[RSF_B_SECOND_MOVE] = fi.second_move;
    status_word[RSF_B_ZEROWAIT] = post_stop_wait_interval;
    status_word[RSF_B_VZERO] = st_vzero;
    status_word[RSF_B_POS_REACHED] = st_pos_reached;
    status_word[RSF_B_VEL_REACHED] = st_vel_reached;
    status_word[RSF_B_EV_POS] = fi.pos_event;
    status_word[RSF_B_EV_STALL] = fi.stall_event;
    status_word[RSF_B_EV_STOP_R] = fi.stop_r_event;
    status_word[RSF_B_EV_STOP_L] = fi.stop_l_event;
    status_word[RSF_B_SW_R] = ref_switch_r;
    status_word[RSF_B_SW_L] = ref_switch_l;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // event conditions handed to the flag flops
  assign fi.clr_second_move = wr_status & w1c_hit(wr_data, wr_strb, RSF_B_SECOND_MOVE);
  assign fi.clr_pos_event = wr_status & w1c_hit(wr_data, wr_strb, RSF_B_EV_POS);
  assign fi.clr_stall_event = wr_status & w1c_hit(wr_data, wr_strb, RSF_B_EV_STALL);
  assign fi.reversal_seen = reversal_pulse;
  assign fi.pos_reached = st_pos_reached;
  assign fi.stall_seen = stall_detect & ctrl_reg[RSF_C_STALL_EN];
  assign fi.stop_l_cond = (stop_l_en & ref_switch_l) | (vstop_l_en & virtual_stop_l_hit);
  assign fi.stop_r_cond = (stop_r_en & ref_switch_r) | (vstop_r_en & virtual_stop_r_hit);
  assign fi.stop_l_release = ramp_hold_mode | move_cmd_right | ~(stop_l_en | vstop_l_en);
  assign fi.stop_r_release = ramp_hold_mode | move_cmd_left | ~(stop_r_en | vstop_r_en);
  assign fi.stop_l_keep = soft_stop & moving_left;
  assign fi.stop_r_keep = soft_stop & moving_right;

  assign irq_next = fi.pos_event | fi.stall_event | fi.stop_l_event | fi.stop_r_event;

  rsf_flags u_flags (
    .clock(clock),
    .rst(rst),
    .fi(fi)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // registered outputs
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      ctrl_reg <= RSF_CTRL_RESET;
      irq_reg <= 1'b0;
      stall_out_reg <= 1'b0;
      stop_l_out_reg <= 1'b0;
      stop_r_out_reg <= 1'b0;
    end
    else
    begin
      ctrl_reg <= ctrl_next;
      irq_reg <= irq_next;
      stall_out_reg <= fi.stall_event;
      stop_l_out_reg <= fi.stop_l_event;
      stop_r_out_reg <= fi.stop_r_event;
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign interrupt_out = irq_reg;
  assign stall_halt_event = stall_out_reg;
  assign stop_left_active = stop_l_out_reg;
  assign stop_right_active = stop_r_out_reg;
endmodule // rsf_top

/* File: verification/rsf_asserts.sv */
// checker for the ramp status block, bound to its top module
// assumes one clock domain with async active high reset
`timescale 1ns/1ps
module rsf_asserts
  import rsf_pkg::*;
#(
  parameter int POS_W = 32
)
(
  input wire logic clock,
  input wire logic rst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [POS_W-1:0] actual_position,
  input wire logic [POS_W-1:0] target_position,
  input wire logic stall_detect,
  input wire logic ref_switch_l,
  input wire logic virtual_stop_l_hit,
  input wire logic ramp_hold_mode,
  input wire logic move_cmd_right,
  input wire logic move_cmd_left,
  input wire logic interrupt_out,
  input wire logic stall_halt_event,
  input wire logic stop_left_active,
  input wire logic stop_right_active
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  //////////////////////////////////////////////////
  sequence aw_w_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence ar_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  chk_write_answer: assert property (aw_w_take |=> s_axi_bvalid)
    else $error("write answer missing");
  chk_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  chk_read_answer: assert property (ar_take |=> s_axi_rvalid)
    else $error("read answer missing");
  chk_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  chk_irq_or: assert property (stall_halt_event || stop_left_active || stop_right_active |-> interrupt_out)
    else $error("interrupt low with event set");
  chk_pos_irq: assert property ($rose(actual_position == target_position) |-> ##2 interrupt_out)
    else $error("position event not latched");
  chk_stall_cause: assert property ($rose(stall_halt_event) |-> $past(stall_detect, 2))
    else $error("stall event without stall");
  chk_stop_l_cause: assert property ($rose(stop_left_active) |-> $past(ref_switch_l, 2) || $past(virtual_stop_l_hit, 2))
    else $error("left stop without cause");
  chk_hold_clears: assert property (ramp_hold_mode |-> ##2 !(stop_left_active || stop_right_active))
    else $error("stop kept in hold");
  chk_opp_move: assert property (move_cmd_right |-> ##2 !stop_left_active)
    else $error("left stop kept on right move");
  chk_opp_move_r: assert property (move_cmd_left |-> ##2 !stop_right_active)
    else $error("right stop kept on left move");
endmodule // rsf_asserts
bind rsf_top rsf_asserts #(.POS_W(POS_W)) i_chk (.*);

/* File: verification/rsf_host_model.sv */
// host that reads and clears the flags over AXI4-Lite
// assumes the tb calls wr and rd; slow delays bready and rready
`timescale 1ns/1ps
module rsf_host_model
  import rsf_pkg::*;
(
  input wire logic clock,
  output logic [RSF_ADDR_W-1:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [RSF_ADDR_W-1:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  int slow = 0;
  initial
  begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
  end
  //////////////////////////////////////////////////
  // w1c clears travel as ordinary writes
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    output logic [1:0] resp);
    logic aw;
    logic w;
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1'b1;
    aw = 1'b1;
    w = 1'b1;
    while (aw || w)
    begin
      @(posedge clock);
      if (aw && s_axi_awready)
      begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~a;
      end
      if (w && s_axi_wready)
      begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~d;
      end
    end
    repeat (slow) @(posedge clock);
    s_axi_bready <= 1'b1;
    do @(posedge clock); while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge clock); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    s_axi_araddr <= ~a;
    repeat (slow) @(posedge clock);
    s_axi_rready <= 1'b1;
    do @(posedge clock); while (!s_axi_rvalid);
    d = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
endmodule // rsf_host_model

/* File: verification/ramp_status_event_flags_tb_top.sv */
// self-checking bench of the ramp status and event flag block
// assumes the host model drives the register bus
`timescale 1ns/1ps
module ramp_status_event_flags_tb_top;
  import rsf_pkg::*;
  localparam logic [7:0] A_ST = {RSF_IDX_STATUS, 2'b00};
  localparam logic [7:0] A_CT = {RSF_IDX_CTRL, 2'b00};
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [RSF_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] actual_position = 32'h1;
  logic [31:0] target_position = 32'h0;
  logic [22:0] actual_velocity = 23'h0;
  logic [22:0] programmed_top_velocity = 23'h5;
  logic post_stop_wait_interval = 1'b0, reversal_pulse = 1'b0, stall_detect = 1'b0;
  logic ref_switch_l = 1'b0, ref_switch_r = 1'b0, virtual_stop_l_hit = 1'b0;
  logic virtual_stop_r_hit = 1'b0, ramp_hold_mode = 1'b0, move_cmd_left = 1'b0;
  logic move_cmd_right = 1'b0, moving_left = 1'b0, moving_right = 1'b0;
  logic interrupt_out, stall_halt_event, stop_left_active, stop_right_active;
  int miscompares = 0;
  int cmp_count = 0;
  rsf_top #(.POS_W(32), .VEL_W(23)) i_dut (.*);
  rsf_host_model i_host (.*);
  initial
  begin
    forever #4 clock = ~clock;
  end
  //////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    check({31'h0, got}, {31'h0, exp});
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic rds(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    i_host.rd(a, d, r);
    check(d, exp);
  endtask
  task automatic wrt(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [1:0] r;
    i_host.wr(a, d, s, r);
    check({30'h0, r}, {30'h0, (a == A_ST || a == A_CT) ? RSF_RESP_OKAY : RSF_RESP_SLVERR});
  endtask
  task automatic stop_test();
    if (miscompares == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  //////////////////////////////////////////////////
  task automatic t_regs();
    logic [31:0] d;
    logic [1:0] r;
    rds(A_ST, 32'h0400);
    rds(A_CT, 32'h0);
    wrt(8'h10, 32'hffff_ffff, 4'hf);
    i_host.rd(8'h10, d, r);
    check(d, 32'h0);
    check({30'h0, r}, {30'h0, RSF_RESP_SLVERR});
    wrt(A_CT, 32'h2a, 4'hf);
    rds(A_CT, 32'h2a);
    wrt(A_CT, 32'h0, 4'hf);
  endtask
  task automatic t_live();
    actual_position <= 32'h0;
    actual_velocity <= 23'h5;
    post_stop_wait_interval <= 1'b1;
    virtual_stop_r_hit <= 1'b1;
    ref_switch_l <= 1'b1;
    tick(3);
    rds(A_ST, 32'h8b81);
    chk1(interrupt_out, 1'b1);
    i_host.slow = 2;
    wrt(A_ST, 32'h80, 4'h1);
    rds(A_ST, 32'h8b01);
    i_host.slow = 0;
    chk1(interrupt_out, 1'b0);
    {post_stop_wait_interval, virtual_stop_r_hit, ref_switch_l} <= 3'b000;
    actual_position <= 32'h1;
    actual_velocity <= 23'h0;
    tick(3);
  endtask
  task automatic t_rev();
    reversal_pulse <= 1'b1;
    tick(1);
    reversal_pulse <= 1'b0;
    tick(2);
    wrt(A_ST, 32'h1000, 4'h1);
    rds(A_ST, 32'h1400);
    wrt(A_ST, 32'h1000, 4'h2);
    rds(A_ST, 32'h0400);
  endtask
  task automatic t_stall();
    stall_detect <= 1'b1;
    tick(1);
    stall_detect <= 1'b0;
    tick(3);
    chk1(stall_halt_event, 1'b0);
    wrt(A_CT, 32'h20, 4'hf);
    stall_detect <= 1'b1;
    tick(1);
    stall_detect <= 1'b0;
    tick(3);
    chk1(stall_halt_event, 1'b1);
    rds(A_ST, 32'h0440);
    wrt(A_ST, 32'h40, 4'h1);
    tick(2);
    chk1(stall_halt_event, 1'b0);
    chk1(interrupt_out, 1'b0);
  endtask
  task automatic t_stop();
    wrt(A_CT, 32'h0f, 4'hf);
    ref_switch_r <= 1'b1;
    tick(3);
    rds(A_ST, 32'h0422);
    ramp_hold_mode <= 1'b1;
    tick(3);
    chk1(stop_right_active, 1'b0);
    ramp_hold_mode <= 1'b0;
    ref_switch_r <= 1'b0;
    virtual_stop_l_hit <= 1'b1;
    tick(3);
    rds(A_ST, 32'h4410);
    move_cmd_right <= 1'b1;
    tick(3);
    chk1(stop_left_active, 1'b0);
    move_cmd_right <= 1'b0;
    tick(3);
    chk1(stop_left_active, 1'b1);
    wrt(A_CT, 32'h0b, 4'hf);
    tick(2);
    chk1(stop_left_active, 1'b0);
    virtual_stop_l_hit <= 1'b0;
    wrt(A_CT, 32'h11, 4'hf);
    ref_switch_l <= 1'b1;
    moving_left <= 1'b1;
    tick(3);
    ref_switch_l <= 1'b0;
    tick(3);
    chk1(stop_left_active, 1'b1);
    moving_left <= 1'b0;
    tick(3);
    chk1(stop_left_active, 1'b0);
    wrt(A_CT, 32'h12, 4'hf);
    ref_switch_r <= 1'b1;
    moving_right <= 1'b1;
    tick(3);
    ref_switch_r <= 1'b0;
    tick(3);
    chk1(stop_right_active, 1'b1);
    move_cmd_left <= 1'b1;
    tick(3);
    chk1(stop_right_active, 1'b0);
    {move_cmd_left, moving_right} <= 2'b00;
    tick(2);
  endtask
  //////////////////////////////////////////////////
  initial
  begin
    tick(20);
    rst <= 1'b0;
    tick(2);
    t_regs();
    t_live();
    t_rev();
    t_stall();
    t_stop();
    stop_test();
  end
  initial
  begin
    #100us;
    miscompares++;
    stop_test();
  end
endmodule // ramp_status_event_flags_tb_top
